// [src/mct_pkg.sv]
// Function
// - The count advances once per prescaler period, the prescaler being as wide as the counter, 32 or 16 bits.
// - Software selects timer operation, counting prescaled clocks, or counter operation, counting edges of the event input.
// - There are four match registers, each compared against the running count.
// - A match may leave the counter running, with a pending interrupt only when enabled for that match.
// - A match may stop the counter, optionally with an interrupt.
// - A match may return the counter to zero, optionally with an interrupt.
// - Each of four match outputs takes its selected action on its match: low, high, toggle or nothing.
// - A selected transition of the capture input copies the count into the capture register.
// - A capture event raises an interrupt when that is enabled.
// - A selected capture transition may clear both the count and the prescaler.
// - Clearing on the leading edge and capturing on the trailing edge measures a pulse width.
`default_nettype none
package mct_pkg;
	// Counter width and match channel count
	localparam int CNT_W_DEF = 32;
	localparam int NUM_MATCH = 4;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_COUNT = 8'h04;
	localparam logic [7:0] OFS_PRESCALE = 8'h08;
	localparam logic [7:0] OFS_PRECOUNT = 8'h0c;
	localparam logic [7:0] OFS_MATCH0 = 8'h10;
	localparam logic [7:0] OFS_MATCH_STEP = 8'h04;
	localparam logic [7:0] OFS_MATCH_CTRL = 8'h20;
	localparam logic [7:0] OFS_OUT_CTRL = 8'h24;
	localparam logic [7:0] OFS_OUT_STATE = 8'h28;
	localparam logic [7:0] OFS_CAP_CTRL = 8'h2c;
	localparam logic [7:0] OFS_CAPTURE = 8'h30;
	localparam logic [7:0] OFS_INT_STATUS = 8'h34;
	localparam logic [7:0] OFS_INT_MASK = 8'h38;
	localparam logic [7:0] OFS_STATUS = 8'h3c;

	// Control register fields
	localparam int CTRL_RUN = 0;
	localparam int CTRL_HOLD = 1;
	localparam int CTRL_EVMODE = 2;
	localparam int CTRL_EDGE = 3;

	// Edge selection codes, bit 0 rising and bit 1 falling
	localparam logic [1:0] EDGE_NONE = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;

	// Match control, three bits per channel
	localparam int MC_INT = 0;
	localparam int MC_RST = 1;
	localparam int MC_STOP = 2;
	localparam int MC_STRIDE = 3;

	// Match output actions, two bits per channel
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_LOW = 2'h1;
	localparam logic [1:0] ACT_HIGH = 2'h2;
	localparam logic [1:0] ACT_TOGGLE = 2'h3;
	localparam int ACT_STRIDE = 2;

	// Capture control fields
	localparam int CAP_EDGE = 0;
	localparam int CAP_INT = 2;
	localparam int CAP_CLR = 3;
	localparam int CAP_CTRL_W = 5;

	// Interrupt bits: matches low, capture above them
	localparam int INT_CAP = NUM_MATCH;
	localparam int INT_W = NUM_MATCH + 1;

	// Status register fields
	localparam int STS_RUN = 0;
	localparam int STS_CAPLVL = 1;
	localparam int STS_EVLVL = 2;

	// Reset values
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	localparam logic [NUM_MATCH-1:0] RST_OUT = 4'h0;

	// Byte offset of match register n
	function automatic logic [7:0] match_ofs(input int n);
		return OFS_MATCH0 + 8'(n) * OFS_MATCH_STEP;
	endfunction
endpackage
`default_nettype wire

// [src/mct_edge.sv]
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser with edge pulses for one pin
module mct_edge (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic pin,
	output logic level,
	output logic rise,
	output logic fall
);
	logic meta;
	logic sync;
	logic prev;

	// First flop feeds only the second
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta <= 1'b0;
			sync <= 1'b0;
			prev <= 1'b0;
		end else begin
			meta <= pin;
			sync <= meta;
			prev <= sync;
		end
	end

	// Edges seen two to three clocks after the pin moves
	assign level = sync;
	assign rise = sync & ~prev;
	assign fall = ~sync & prev;
endmodule
`default_nettype wire

// [src/mct_timer.sv]
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Counter/timer with prescaler, four matches and one capture
module mct_timer
	import mct_pkg::*;
#(
	parameter int W = CNT_W_DEF
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic count_in,
	input wire logic cap_in,
	output logic [NUM_MATCH-1:0] match_out,
	output logic irq
);
	// Only the two documented widths are served
	generate
		if (W != 32 && W != 16) begin : g_bad_width
			$error("mct_timer: W must be 32 or 16");
		end
	endgenerate

	// Software-visible state
	logic run;
	logic hold;
	logic ev_mode;
	logic [1:0] cnt_edge;
	logic [W-1:0] count;
	logic [W-1:0] prescale;
	logic [W-1:0] precount;
	logic [W-1:0] match_val [NUM_MATCH];
	logic [MC_STRIDE*NUM_MATCH-1:0] match_ctrl;
	logic [ACT_STRIDE*NUM_MATCH-1:0] out_ctrl;
	logic [CAP_CTRL_W-1:0] cap_ctrl;
	logic [W-1:0] capture;
	logic [INT_W-1:0] int_status;
	logic [INT_W-1:0] int_mask;

	// Internal decode and event terms
	logic ev_level;
	logic ev_rise;
	logic ev_fall;
	logic cap_level;
	logic cap_rise;
	logic cap_fall;
	logic tick;
	logic pre_wrap;
	logic [NUM_MATCH-1:0] hit;
	logic [NUM_MATCH-1:0] hit_rst;
	logic [NUM_MATCH-1:0] hit_stop;
	logic [NUM_MATCH-1:0] hit_int;
	logic cap_event;
	logic cap_clear;
	logic [INT_W-1:0] int_set;
	logic [INT_W-1:0] int_clr;
	logic [31:0] rd_val;

	// Zero-extend a count to the bus width
	function automatic logic [31:0] zx(input logic [W-1:0] v);
		return 32'(v);
	endfunction

	// Edge selection shared by counting, capture and clear
	function automatic logic edge_sel(
		input logic [1:0] sel,
		input logic r,
		input logic f
	);
		return (sel[0] & r) | (sel[1] & f);
	endfunction

	// Write strobe aimed at one offset
	function automatic logic wr_at(input logic [7:0] ofs);
		return wr && (addr == ofs);
	endfunction

	// Next level of a match output for its action
	function automatic logic out_next(
		input logic [1:0] act,
		input logic cur
	);
		logic r;
		r = cur;
		unique case (act)
			ACT_NONE: r = cur;
			ACT_LOW: r = 1'b0;
			ACT_HIGH: r = 1'b1;
			ACT_TOGGLE: r = ~cur;
		endcase
		return r;
	endfunction

	// Event input for counter operation
	mct_edge u_ev_edge (
		.clk(clk),
		.rst_b(rst_b),
		.pin(count_in),
		.level(ev_level),
		.rise(ev_rise),
		.fall(ev_fall)
	);

	// Capture input
	mct_edge u_cap_edge (
		.clk(clk),
		.rst_b(rst_b),
		.pin(cap_in),
		.level(cap_level),
		.rise(cap_rise),
		.fall(cap_fall)
	);

	// Prescaler period ends when it reaches the terminal value
	assign pre_wrap = (precount == prescale);

	// Advance strobe; in event mode the prescaler is bypassed
	always_comb begin
		tick = 1'b0;
		if (run && !hold) begin
			if (ev_mode) begin
				tick = edge_sel(cnt_edge, ev_rise, ev_fall);
			end else begin
				tick = pre_wrap;
			end
		end
	end

	// Compare only on advance, so each value matches at most once
	always_comb begin
		for (int i = 0; i < NUM_MATCH; i++) begin
			hit[i] = tick && (count == match_val[i]);
			hit_rst[i] = hit[i] & match_ctrl[MC_STRIDE*i+MC_RST];
			hit_stop[i] = hit[i] & match_ctrl[MC_STRIDE*i+MC_STOP];
			hit_int[i] = hit[i] & match_ctrl[MC_STRIDE*i+MC_INT];
		end
	end

	// Capture and clear events from the selected edges
	assign cap_event = edge_sel(cap_ctrl[CAP_EDGE+:2], cap_rise,
		cap_fall);
	assign cap_clear = edge_sel(cap_ctrl[CAP_CLR+:2], cap_rise,
		cap_fall);

	// Interrupt set and write-one-to-clear terms
	assign int_set = {cap_event & cap_ctrl[CAP_INT], hit_int};
	assign int_clr = wr_at(OFS_INT_STATUS) ? wdata[INT_W-1:0] :
		{INT_W{1'b0}};

	// Control register; a stop match drops the run bit
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			run <= 1'b0;
			hold <= 1'b0;
			ev_mode <= 1'b0;
			cnt_edge <= EDGE_RISE;
		end else if (wr_at(OFS_CTRL)) begin
			run <= wdata[CTRL_RUN];
			hold <= wdata[CTRL_HOLD];
			ev_mode <= wdata[CTRL_EVMODE];
			cnt_edge <= wdata[CTRL_EDGE+:2];
		end else if (|hit_stop) begin
			run <= 1'b0;
		end
	end

	// Count: hold and capture clear beat a write, a write beats advance
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count <= W'(RST_ZERO);
		end else if (hold || cap_clear) begin
			count <= W'(RST_ZERO);
		end else if (wr_at(OFS_COUNT)) begin
			count <= wdata[W-1:0];
		end else if (tick) begin
			if (|hit_rst) begin
				count <= W'(RST_ZERO);
			end else begin
				count <= count + 1'b1;
			end
		end
	end

	// Prescaler counts system clocks while running in timer mode
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			precount <= W'(RST_ZERO);
		end else if (hold || cap_clear) begin
			precount <= W'(RST_ZERO);
		end else if (wr_at(OFS_PRECOUNT)) begin
			precount <= wdata[W-1:0];
		end else if (run && !ev_mode) begin
			precount <= pre_wrap ? W'(RST_ZERO) :
				precount + 1'b1;
		end
	end

	// Prescaler terminal value
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prescale <= W'(RST_ZERO);
		end else if (wr_at(OFS_PRESCALE)) begin
			prescale <= wdata[W-1:0];
		end
	end

	// Match values, one word each
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < NUM_MATCH; i++) begin
				match_val[i] <= W'(RST_ZERO);
			end
		end else begin
			for (int i = 0; i < NUM_MATCH; i++) begin
				if (wr_at(match_ofs(i))) begin
					match_val[i] <= wdata[W-1:0];
				end
			end
		end
	end

	// Match and output action configuration
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			match_ctrl <= '0;
			out_ctrl <= '0;
		end else begin
			if (wr_at(OFS_MATCH_CTRL)) begin
				match_ctrl <= wdata[MC_STRIDE*NUM_MATCH-1:0];
			end
			if (wr_at(OFS_OUT_CTRL)) begin
				out_ctrl <= wdata[ACT_STRIDE*NUM_MATCH-1:0];
			end
		end
	end

	// Match outputs; a hit in the write cycle wins over software
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			match_out <= RST_OUT;
		end else begin
			for (int i = 0; i < NUM_MATCH; i++) begin
				if (hit[i]) begin
					match_out[i] <= out_next(
						out_ctrl[ACT_STRIDE*i+:2],
						match_out[i]);
				end else if (wr_at(OFS_OUT_STATE)) begin
					match_out[i] <= wdata[i];
				end
			end
		end
	end

	// Capture configuration
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cap_ctrl <= '0;
		end else if (wr_at(OFS_CAP_CTRL)) begin
			cap_ctrl <= wdata[CAP_CTRL_W-1:0];
		end
	end

	// Snapshot takes the count before any clear of the same edge
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			capture <= W'(RST_ZERO);
		end else if (cap_event) begin
			capture <= count;
		end
	end

	// Pending flags: a new event beats a clear in the same cycle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			int_status <= '0;
		end else begin
			int_status <= int_set | (int_status & ~int_clr);
		end
	end

	// Interrupt mask
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			int_mask <= '0;
		end else if (wr_at(OFS_INT_MASK)) begin
			int_mask <= wdata[INT_W-1:0];
		end
	end

	// Level interrupt from flops only
	assign irq = |(int_status & int_mask);

	// Read decode; unmapped offsets read zero
	always_comb begin
		rd_val = RST_ZERO;
		unique case (addr)
			OFS_CTRL: begin
				rd_val[CTRL_RUN] = run;
				rd_val[CTRL_HOLD] = hold;
				rd_val[CTRL_EVMODE] = ev_mode;
				rd_val[CTRL_EDGE+:2] = cnt_edge;
			end
			OFS_COUNT: rd_val = zx(count);
			OFS_PRESCALE: rd_val = zx(prescale);
			OFS_PRECOUNT: rd_val = zx(precount);
			OFS_MATCH_CTRL: begin
				rd_val[MC_STRIDE*NUM_MATCH-1:0] = match_ctrl;
			end
			OFS_OUT_CTRL: begin
				rd_val[ACT_STRIDE*NUM_MATCH-1:0] = out_ctrl;
			end
			OFS_OUT_STATE: rd_val[NUM_MATCH-1:0] = match_out;
			OFS_CAP_CTRL: rd_val[CAP_CTRL_W-1:0] = cap_ctrl;
			OFS_CAPTURE: rd_val = zx(capture);
			OFS_INT_STATUS: rd_val[INT_W-1:0] = int_status;
			OFS_INT_MASK: rd_val[INT_W-1:0] = int_mask;
			OFS_STATUS: begin
				rd_val[STS_RUN] = run;
				rd_val[STS_CAPLVL] = cap_level;
				rd_val[STS_EVLVL] = ev_level;
			end
			default: rd_val = RST_ZERO;
		endcase
		for (int i = 0; i < NUM_MATCH; i++) begin
			if (addr == match_ofs(i)) begin
				rd_val = zx(match_val[i]);
			end
		end
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata <= RST_ZERO;
		end else if (rd) begin
			rdata <= rd_val;
		end else begin
			rdata <= RST_ZERO;
		end
	end
endmodule
`default_nettype wire

// [testbench/mct_timer_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
// Port checks; idle means the last control write cleared run and hold
module mct_timer_chk
	import mct_pkg::*;
#(
	parameter int W = CNT_W_DEF
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [31:0] rdata,
	input wire logic count_in,
	input wire logic cap_in,
	input wire logic [NUM_MATCH-1:0] match_out,
	input wire logic irq
);
	localparam logic [31:0] MSK = (W == 32) ? 32'hffff_ffff : 32'h0000_ffff;
	logic idle;
	logic [3:0] quiet;
	logic w_ist;
	logic w_msk;
	logic w_out;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Register strobes of interest
	assign w_ist = wr && addr == OFS_INT_STATUS;
	assign w_msk = wr && addr == OFS_INT_MASK;
	assign w_out = wr && addr == OFS_OUT_STATE;
	// Shadow of run and hold; a stop on match is not seen here
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			idle <= 1'b1;
		else if (wr && addr == OFS_CTRL)
			idle <= wdata[1:0] == 2'h0;
	end
	// Pin quiet time, so synchroniser latency cannot surprise us
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			quiet <= 4'h0;
		else if ($changed(cap_in) || $changed(count_in))
			quiet <= 4'h0;
		else if (quiet != 4'hf)
			quiet <= quiet + 4'h1;
	end
	sequence s_wr(a);
		wr && addr == a;
	endsequence
	sequence s_rd(a);
		rd && !wr && addr == a;
	endsequence
	property p_irq_sticky;
		irq && !w_ist && !w_msk |=> irq;
	endproperty
	property p_mask_off;
		w_msk && wdata[INT_W-1:0] == '0 |=> !irq;
	endproperty
	property p_out_hold;
		idle && !w_out |=> $stable(match_out);
	endproperty
	property p_out_wr;
		idle && w_out |=> match_out == $past(wdata[3:0]);
	endproperty
	property p_no_rise;
		idle && quiet > 4 && !w_msk |=> !$rose(irq);
	endproperty
	property p_match_rw;
		s_wr(OFS_MATCH0) ##1 s_rd(OFS_MATCH0)
			|=> rdata == ($past(wdata, 2) & MSK);
	endproperty
	property p_cnt_frozen;
		(idle && quiet > 4) ##0 s_wr(OFS_COUNT) ##1 s_rd(OFS_COUNT)
			|=> rdata == ($past(wdata, 2) & MSK);
	endproperty
	property p_cap_ro;
		(quiet > 4) ##0 s_rd(OFS_CAPTURE) ##1 s_wr(OFS_CAPTURE)
			##1 s_rd(OFS_CAPTURE) |=> rdata == $past(rdata, 2);
	endproperty
	a_irq_sticky: assert property (p_irq_sticky)
		else $error("irq dropped without a write");
	a_mask_off: assert property (p_mask_off)
		else $error("irq high with all masked");
	a_out_hold: assert property (p_out_hold)
		else $error("match output moved while stopped");
	a_out_wr: assert property (p_out_wr)
		else $error("output state write lost");
	a_no_rise: assert property (p_no_rise)
		else $error("irq rose with no event");
	a_match_rw: assert property (p_match_rw)
		else $error("match value readback wrong");
	a_cnt_frozen: assert property (p_cnt_frozen)
		else $error("count moved while stopped");
	a_cap_ro: assert property (p_cap_ro)
		else $error("capture changed by a write");
endmodule
bind mct_timer mct_timer_chk #(.W(W)) chk_u (
	.clk(clk),
	.rst_b(rst_b),
	.addr(addr),
	.wdata(wdata),
	.wr(wr),
	.rd(rd),
	.rdata(rdata),
	.count_in(count_in),
	.cap_in(cap_in),
	.match_out(match_out),
	.irq(irq)
);
`default_nettype wire

// [testbench/mct_pins.sv]
`timescale 1ns/1ps
`default_nettype none
// External pin driver; levels held for several clocks to clear sync
module mct_pins (
	input wire logic clk,
	output logic count_in,
	output logic cap_in
);
	// Both pins idle low
	initial begin
		count_in = 1'b0;
		cap_in = 1'b0;
	end
	task automatic ev_pulses(input int n);
		repeat (n) begin
			count_in <= 1'b1;
			repeat (3) @(posedge clk);
			count_in <= 1'b0;
			repeat (3) @(posedge clk);
		end
	endtask
	task automatic cap_pulse(input int len);
		cap_in <= 1'b1;
		repeat (len) @(posedge clk);
		cap_in <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// [testbench/test_match_capture_counter_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module test_match_capture_counter_timer
	import mct_pkg::*;
;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic count_in;
	logic cap_in;
	logic [NUM_MATCH-1:0] match_out;
	logic irq;
	int n_errors = 0;
	int num_checks = 0;
	// 200 MHz clock
	always #2.5 clk = ~clk;
	mct_timer dut_u (
		.clk(clk),
		.rst_b(rst_b),
		.addr(addr),
		.wdata(wdata),
		.wr(wr),
		.rd(rd),
		.rdata(rdata),
		.count_in(count_in),
		.cap_in(cap_in),
		.match_out(match_out),
		.irq(irq)
	);
	mct_pins pins_u (
		.clk(clk),
		.count_in(count_in),
		.cap_in(cap_in)
	);
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// One bus cycle; strobes stay up until the caller changes them
	task automatic cyc(input logic w, input logic r, input logic [7:0] a,
			input logic [31:0] d);
		wr <= w;
		rd <= r;
		addr <= a;
		wdata <= d;
		@(posedge clk);
	endtask
	task automatic wreg(input logic [7:0] a, input logic [15:0] d);
		cyc(1'b1, 1'b0, a, 32'(d));
		cyc(1'b0, 1'b0, a, 32'(d));
	endtask
	// Read data only stands for one cycle, so grab it mid-cycle
	task automatic rreg(input logic [7:0] a, output logic [31:0] d);
		cyc(1'b0, 1'b1, a, 32'h0000_0000);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
		@(posedge clk);
	endtask
	task automatic creg(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		rreg(a, v);
		chk(v, e);
	endtask
	task automatic cbit(input logic b, input logic e);
		@(negedge clk);
		chk(32'(b), 32'(e));
		@(posedge clk);
	endtask
	task automatic t_cont();
		int n;
		logic [31:0] v;
		creg(OFS_CTRL, 32'h0000_0008);
		creg(OFS_INT_STATUS, 32'h0000_0000);
		creg(8'h40, 32'h0000_0000);
		cyc(1'b1, 1'b0, OFS_MATCH0, 32'h0000_0005);
		creg(OFS_MATCH0, 32'h0000_0005);
		wreg(OFS_PRESCALE, 16'h0003);
		wreg(OFS_MATCH_CTRL, 16'h0001);
		wreg(OFS_INT_MASK, 16'h0001);
		wreg(OFS_CTRL, 16'h0001);
		n = 0;
		while (irq !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		chk(32'(n >= 18 && n <= 26), 32'h0000_0001);
		@(posedge clk);
		rreg(OFS_COUNT, v);
		chk(32'(v >= 6 && v <= 9), 32'h0000_0001);
		creg(OFS_INT_STATUS, 32'h0000_0001);
		wreg(OFS_INT_STATUS, 16'h0001);
		cbit(irq, 1'b0);
	endtask
	// Stop on match, each output action in turn
	task automatic t_out();
		logic [1:0] a;
		for (int i = 0; i < 4; i++) begin
			a = 2'(i + 1);
			wreg(OFS_CTRL, 16'h0000);
			wreg(OFS_PRESCALE, 16'h0000);
			// Prescaler left above zero would wrap the whole range
			wreg(OFS_PRECOUNT, 16'h0000);
			wreg(OFS_COUNT, 16'h0000);
			wreg(OFS_OUT_STATE, (a == ACT_HIGH) ? 16'h0000 : 16'h0004);
			wreg(OFS_MATCH0 + 8'h08, 16'h0001);
			wreg(OFS_MATCH_CTRL, 16'h0100);
			wreg(OFS_OUT_CTRL, 16'(a) << 4);
			wreg(OFS_CTRL, 16'h0001);
			repeat (8) @(posedge clk);
			cbit(match_out[2], a == ACT_HIGH || a == ACT_NONE);
			creg(OFS_COUNT, 32'h0000_0002);
			creg(OFS_STATUS, 32'h0000_0000);
		end
	endtask
	task automatic t_rst();
		logic m;
		int n;
		wreg(OFS_CTRL, 16'h0000);
		wreg(OFS_MATCH0 + 8'h04, 16'h0002);
		wreg(OFS_MATCH_CTRL, 16'h0010);
		wreg(OFS_OUT_CTRL, 16'h000c);
		wreg(OFS_CTRL, 16'h0001);
		// Step off the edge that may launch the first toggle
		@(negedge clk);
		for (int k = 0; k < 2; k++) begin
			m = match_out[1];
			n = 0;
			while (match_out[1] === m && n < 20) begin
				@(negedge clk);
				n++;
			end
		end
		chk(32'(n), 32'h0000_0003);
		@(posedge clk);
		wreg(OFS_CTRL, 16'h0000);
	endtask
	task automatic t_cap();
		logic [31:0] v;
		wreg(OFS_MATCH_CTRL, 16'h0000);
		wreg(OFS_CAP_CTRL, 16'h000e);
		wreg(OFS_INT_MASK, 16'h0010);
		wreg(OFS_CTRL, 16'h0001);
		pins_u.cap_pulse(40);
		rreg(OFS_CAPTURE, v);
		chk(32'(v >= 39 && v <= 40), 32'h0000_0001);
		creg(OFS_INT_STATUS, 32'h0000_0010);
		wreg(OFS_CTRL, 16'h0000);
		cyc(1'b0, 1'b1, OFS_CAPTURE, 32'h0000_0000);
		cyc(1'b1, 1'b0, OFS_CAPTURE, 32'hffff_ffff);
		creg(OFS_CAPTURE, v);
		cbit(irq, 1'b1);
		wreg(OFS_INT_MASK, 16'h0000);
		cbit(irq, 1'b0);
		wreg(OFS_INT_STATUS, 16'h001f);
		creg(OFS_INT_STATUS, 32'h0000_0000);
	endtask
	// Event counting for each edge selection
	task automatic t_ev();
		for (int i = 0; i < 4; i++) begin
			wreg(OFS_CTRL, 16'h0000);
			cyc(1'b1, 1'b0, OFS_COUNT, 32'h0000_0000);
			creg(OFS_COUNT, 32'h0000_0000);
			wreg(OFS_CTRL, 16'h0005 | (16'(i) << 3));
			pins_u.ev_pulses(5);
			repeat (3) @(posedge clk);
			wreg(OFS_CTRL, 16'h0000);
			creg(OFS_COUNT, (i == 0) ? 0 : (i == 3) ? 10 : 5);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		t_cont();
		t_out();
		t_rst();
		t_cap();
		t_ev();
		end_of_test();
	end
	// Watchdog at 10000 cycles, far beyond the few hundred cycles needed
	initial begin
		#50000;
		n_errors++;
		end_of_test();
	end
endmodule
`default_nettype wire
